// File: rtl/jtb_pkg.sv
// Purpose: Shared constants, types and decoding for the test access port block.
// Assumes: Chain layout matches the larger package front portion; pins follow in pairs.
// Notes: Instruction codes and chain bit positions live here only.
package jtb_pkg;

  // Instruction register width, reset and capture values.
  localparam int JTB_IR_W = 16;
  localparam logic [15:0] JTB_IR_RESET = 16'h0000;
  localparam logic [15:0] JTB_IR_CAPTURE = 16'h0001;

  // Instruction codes.
  localparam logic [15:0] JTB_OP_EXTEST = 16'h0000;
  localparam logic [15:0] JTB_OP_INSTR_A = 16'h0002;
  localparam logic [15:0] JTB_OP_IDCODE = 16'h0004;
  localparam logic [15:0] JTB_OP_BYPASS = 16'hffff;
  localparam logic [15:0] JTB_OP_FL_CTRL = 16'h0082;
  localparam logic [15:0] JTB_OP_FL_DATA = 16'h0083;
  localparam logic [15:0] JTB_OP_FL_ADDR = 16'h0084;
  localparam logic [15:0] JTB_OP_FL_SCALE = 16'h0085;

  // Boundary chain lengths of the two package variants.
  localparam int JTB_BSR_LEN_LARGE = 126;
  localparam int JTB_BSR_LEN_SMALL = 118;

  // Chain bit positions of the front portion.
  localparam int JTB_BIT_RST_EN = 0;
  localparam int JTB_BIT_RST_IN = 1;
  localparam int JTB_BIT_CAN_BASE = 2;
  localparam int JTB_BIT_XTAL = 6;
  localparam int JTB_BIT_PULLUP = 7;
  localparam int JTB_BIT_PORT_BASE = 8;

  // Identification and flash access register sizes.
  localparam int JTB_ID_W = 32;
  localparam int JTB_FLASH_W = 8;
  localparam int JTB_FLASH_REGS = 4;

  // Values after reset of the pin-side and core-side outputs, and the core-side level forced under external test.
  localparam logic JTB_OE_N_RESET = 1'b1;
  localparam logic JTB_OUT_RESET = 1'b0;
  localparam logic JTB_CORE_IN_RESET = 1'b0;
  localparam logic JTB_CORE_IN_FORCE = 1'b1;

  // Test access port controller states, Gray coded along the usual path.
  typedef enum logic [3:0] {
    st_reset = 4'h0, st_idle = 4'h1, st_sel_dr = 4'h3, st_cap_dr = 4'h2,
    st_shift_dr = 4'h6, st_exit1_dr = 4'h7, st_pause_dr = 4'h5, st_exit2_dr = 4'h4,
    st_upd_dr = 4'hc, st_sel_ir = 4'hd, st_cap_ir = 4'hf, st_shift_ir = 4'he,
    st_exit1_ir = 4'ha, st_pause_ir = 4'hb, st_exit2_ir = 4'h9, st_upd_ir = 4'h8
  } jtb_tap_state_e;

  // Data register selected by the current instruction.
  typedef enum logic [2:0] {
    sel_extest = 3'h0, sel_instr_a = 3'h1, sel_id = 3'h3, sel_bypass = 3'h2,
    sel_fl_ctrl = 3'h6, sel_fl_data = 3'h7, sel_fl_addr = 3'h5, sel_fl_scale = 3'h4
  } jtb_dr_sel_e;

  // Unknown codes fall back to bypass so the serial path is always defined.
  function automatic jtb_dr_sel_e jtb_decode(input logic [15:0] code);
    jtb_dr_sel_e s;
    s = sel_bypass;
    case (code)
      JTB_OP_EXTEST: s = sel_extest;
      JTB_OP_INSTR_A: s = sel_instr_a;
      JTB_OP_IDCODE: s = sel_id;
      JTB_OP_FL_CTRL: s = sel_fl_ctrl;
      JTB_OP_FL_DATA: s = sel_fl_data;
      JTB_OP_FL_ADDR: s = sel_fl_addr;
      JTB_OP_FL_SCALE: s = sel_fl_scale;
      default: s = sel_bypass;
    endcase
    return s;
  endfunction : jtb_decode

endpackage : jtb_pkg

// File: rtl/jtb_tap.sv
// Purpose: Test access port with instruction register, data registers and boundary chain.
// Assumes: tck is the tester's clock; clock runs at 50 MHz; rst is synchronous, active high.
// Notes: Pin muxing runs on clock; all serial logic runs on tck; crossings use flop chains.
// Notes on behaviour
// - Standard controller, shift, capture, update on four pins.
// - Instruction register is sixteen bits wide.
// - Instruction register resets to zero, selecting external test.
// - Code 0000 selects chain, captures and drives pins.
// - Code 0002 selects chain, capture only, no driving.
// - Code 0004 selects identification register.
// - Code ffff selects bypass register.
// - Code 0082 selects flash access control register.
// - Code 0083 selects flash access data register.
// - Code 0084 selects flash access address register.
// - Code 0085 selects flash timer scale register.
// - Chain is 126 or 118 cells long.
// - Bits 0 and 1 serve the reset pin.
// - Bits 2 to 5 serve the CAN pins.
// - Bit 6 captures the crystal input, no update.
// - Bit 7 carries the weak pull-up enable.
// - Port zero uses bits 8 to 23 in pairs.
// - Ports one to three start at 24, 40, 56.
// - Port four pins five to seven use 72-77.
// - Port five enables start at bit 78.
// - External test forces core pin inputs to one.
`timescale 1ns/100ps
module jtb_tap
  import jtb_pkg::*;
#(
  parameter int BSR_LEN = JTB_BSR_LEN_LARGE,
  parameter int FLASH_W = JTB_FLASH_W,
  // Identification value is arbitrary; bit 0 stays set as the standard asks.
  parameter logic [31:0] ID_VALUE = 32'h0a5a_5001,
  localparam int NPIN = (BSR_LEN - JTB_BIT_PORT_BASE) / 2
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic [1:0] can_pin_in,
  output logic [1:0] can_pin_out,
  output logic [1:0] can_pin_oe_n,
  input wire logic crystal_input_pin,
  input wire logic [NPIN-1:0] port_pin_in,
  output logic [NPIN-1:0] port_pin_out,
  output logic [NPIN-1:0] port_pin_oe_n,
  output logic weak_pullup_en,
  input wire logic core_rst_drive_en,
  input wire logic [1:0] core_can_oe,
  input wire logic [1:0] core_can_out,
  input wire logic core_weak_pullup_en,
  input wire logic [NPIN-1:0] core_port_oe,
  input wire logic [NPIN-1:0] core_port_out,
  output logic core_rst_in,
  output logic [1:0] core_can_in,
  output logic core_xtal_in,
  output logic [NPIN-1:0] core_port_in
);

  localparam int NIN = NPIN + 4;

  ////////////////////////////////////////////////////////////////////////////
  // Clock domain: pin filtering, capture snapshot and pin muxing.

  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] pin_s1;
  logic [NIN-1:0] pin_s2;
  logic [NIN-1:0] pin_s3;
  logic [NIN-1:0] pin_f;
  logic [BSR_LEN-1:0] cap_snap;
  logic [BSR_LEN-1:0] upd_c1;
  logic [BSR_LEN-1:0] upd_c2;
  logic ext_c1;
  logic ext_c2;
  // Driven in the link domain below; declared here because the crossing reads them first.
  logic [BSR_LEN-1:0] bsr_upd;
  logic ext_mode;

  // Inputs are gathered so one filter serves every pin.
  assign pin_raw = {port_pin_in, crystal_input_pin, can_pin_in, rst_pin_in};

  // Three stages; a level is taken only once the second and third agree.
  always_ff @(posedge clock)
  begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    if (rst)
      pin_f <= '0;
    else
      pin_f <= (pin_f & (pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));
  end

  // Snapshot that the capture cells will load, laid out in chain order.
  always_ff @(posedge clock)
  begin
    if (rst)
      cap_snap <= '0;
    else
    begin
      cap_snap[JTB_BIT_RST_EN] <= core_rst_drive_en;
      cap_snap[JTB_BIT_RST_IN] <= pin_f[0];
      for (int j = 0; j < 2; j++)
      begin
        cap_snap[JTB_BIT_CAN_BASE + 2 * j] <= core_can_oe[j];
        cap_snap[JTB_BIT_CAN_BASE + 2 * j + 1] <= pin_f[1 + j];
      end
      cap_snap[JTB_BIT_XTAL] <= pin_f[3];
      cap_snap[JTB_BIT_PULLUP] <= core_weak_pullup_en;
      for (int k = 0; k < NPIN; k++)
      begin
        cap_snap[JTB_BIT_PORT_BASE + 2 * k] <= core_port_oe[k];
        cap_snap[JTB_BIT_PORT_BASE + 2 * k + 1] <= pin_f[4 + k];
      end
    end
  end

  // Update cells and the test mode come over from tck as levels.
  always_ff @(posedge clock)
  begin
    upd_c1 <= bsr_upd;
    upd_c2 <= upd_c1;
    ext_c1 <= ext_mode;
    ext_c2 <= ext_c1;
  end

  // Pin drivers: core values normally, update cells under external test.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rst_pin_out <= JTB_OUT_RESET;
      rst_pin_oe_n <= JTB_OE_N_RESET;
      can_pin_out <= {2{JTB_OUT_RESET}};
      can_pin_oe_n <= {2{JTB_OE_N_RESET}};
      weak_pullup_en <= JTB_OUT_RESET;
      port_pin_out <= {NPIN{JTB_OUT_RESET}};
      port_pin_oe_n <= {NPIN{JTB_OE_N_RESET}};
    end
    else
    begin
      // The reset pin only ever pulls low, so its data level stays fixed.
      rst_pin_out <= JTB_OUT_RESET;
      rst_pin_oe_n <= ext_c2 ? ~upd_c2[JTB_BIT_RST_EN] : ~core_rst_drive_en;
      for (int j = 0; j < 2; j++)
      begin
        can_pin_oe_n[j] <= ext_c2 ? ~upd_c2[JTB_BIT_CAN_BASE + 2 * j] : ~core_can_oe[j];
        can_pin_out[j] <= ext_c2 ? upd_c2[JTB_BIT_CAN_BASE + 2 * j + 1] : core_can_out[j];
      end
      weak_pullup_en <= ext_c2 ? upd_c2[JTB_BIT_PULLUP] : core_weak_pullup_en;
      for (int k = 0; k < NPIN; k++)
      begin
        port_pin_oe_n[k] <= ext_c2 ? ~upd_c2[JTB_BIT_PORT_BASE + 2 * k] : ~core_port_oe[k];
        port_pin_out[k] <= ext_c2 ? upd_c2[JTB_BIT_PORT_BASE + 2 * k + 1] : core_port_out[k];
      end
    end
  end

  // Core-facing inputs read ones under external test so the core sees no pin noise.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_rst_in <= JTB_CORE_IN_RESET;
      core_can_in <= {2{JTB_CORE_IN_RESET}};
      core_xtal_in <= JTB_CORE_IN_RESET;
      core_port_in <= {NPIN{JTB_CORE_IN_RESET}};
    end
    else if (ext_c2)
    begin
      core_rst_in <= JTB_CORE_IN_FORCE;
      core_can_in <= {2{JTB_CORE_IN_FORCE}};
      core_xtal_in <= JTB_CORE_IN_FORCE;
      core_port_in <= {NPIN{JTB_CORE_IN_FORCE}};
    end
    else
    begin
      core_rst_in <= pin_f[0];
      core_can_in <= pin_f[2:1];
      core_xtal_in <= pin_f[3];
      core_port_in <= pin_f[NIN-1:4];
    end
  end

  chk_core_forced:
    assert property (@(posedge clock) disable iff (rst)
      ext_c2 |=> (core_rst_in && (&core_port_in) && (&core_can_in) && core_xtal_in))
    else $error("core inputs not forced high under external test");

  chk_pullup_follow:
    assert property (@(posedge clock) disable iff (rst)
      (ext_c2 && $stable(upd_c2)) |=> (weak_pullup_en == $past(upd_c2[JTB_BIT_PULLUP])))
    else $error("weak pull-up does not follow its update cell");

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: controller, instruction and data registers on tck.

  logic rst_t1;
  logic rst_t2;
  jtb_tap_state_e tap_state;
  jtb_tap_state_e next_tap_state;
  logic [JTB_IR_W-1:0] ir_sr;
  logic [JTB_IR_W-1:0] ir;
  jtb_dr_sel_e dr_sel;
  logic [BSR_LEN-1:0] bsr_sr;
  logic [BSR_LEN-1:0] cap_t1;
  logic [BSR_LEN-1:0] cap_t2;
  logic [JTB_ID_W-1:0] id_sr;
  logic byp;
  logic [FLASH_W-1:0] fl_sr;
  logic [FLASH_W-1:0] fl_hold [JTB_FLASH_REGS];
  logic [1:0] fl_idx;
  logic fl_sel;
  logic next_tdo;

  // The system reset reaches tck through two flops; tms can also reset the port.
  always_ff @(posedge tck)
  begin
    rst_t1 <= rst;
    rst_t2 <= rst_t1;
  end

  // Controller next state, stepping on tms.
  always_comb
  begin
    next_tap_state = st_reset;
    case (tap_state)
      st_reset: next_tap_state = tms ? st_reset : st_idle;
      st_idle: next_tap_state = tms ? st_sel_dr : st_idle;
      st_sel_dr: next_tap_state = tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: next_tap_state = tms ? st_exit1_dr : st_shift_dr;
      st_shift_dr: next_tap_state = tms ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: next_tap_state = tms ? st_upd_dr : st_pause_dr;
      st_pause_dr: next_tap_state = tms ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: next_tap_state = tms ? st_upd_dr : st_shift_dr;
      st_upd_dr: next_tap_state = tms ? st_sel_dr : st_idle;
      st_sel_ir: next_tap_state = tms ? st_reset : st_cap_ir;
      st_cap_ir: next_tap_state = tms ? st_exit1_ir : st_shift_ir;
      st_shift_ir: next_tap_state = tms ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: next_tap_state = tms ? st_upd_ir : st_pause_ir;
      st_pause_ir: next_tap_state = tms ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: next_tap_state = tms ? st_upd_ir : st_shift_ir;
      st_upd_ir: next_tap_state = tms ? st_sel_dr : st_idle;
      default: next_tap_state = st_reset;
    endcase
  end

  always_ff @(posedge tck)
  begin
    if (rst_t2)
      tap_state <= st_reset;
    else
      tap_state <= next_tap_state;
  end

  // Instruction shift path, with the fixed 01 pattern loaded on capture.
  always_ff @(posedge tck)
  begin
    if (rst_t2)
      ir_sr <= JTB_IR_RESET;
    else if (tap_state == st_cap_ir)
      ir_sr <= JTB_IR_CAPTURE;
    else if (tap_state == st_shift_ir)
      ir_sr <= {tdi, ir_sr[JTB_IR_W-1:1]};
  end

  // Active instruction; the all-zero reset value selects external test.
  always_ff @(posedge tck)
  begin
    if (rst_t2 || tap_state == st_reset)
      ir <= JTB_IR_RESET;
    else if (tap_state == st_upd_ir)
      ir <= ir_sr;
  end

  assign dr_sel = jtb_decode(ir);

  // Mode flag that the clock domain uses to hand the pins to the chain.
  always_ff @(posedge tck)
  begin
    if (rst_t2)
      ext_mode <= 1'b0;
    else
      ext_mode <= (dr_sel == sel_extest);
  end

  // Pin snapshot crosses into tck as levels; a changing pin may land a cycle late.
  always_ff @(posedge tck)
  begin
    cap_t1 <= cap_snap;
    cap_t2 <= cap_t1;
  end

  // Boundary shift cells: capture only in capture, shift only in shift.
  always_ff @(posedge tck)
  begin
    if (rst_t2)
      bsr_sr <= '0;
    else if (dr_sel == sel_extest || dr_sel == sel_instr_a)
    begin
      if (tap_state == st_cap_dr)
        bsr_sr <= cap_t2;
      else if (tap_state == st_shift_dr)
        bsr_sr <= {tdi, bsr_sr[BSR_LEN-1:1]};
    end
  end

  // Update cells load under either chain instruction; only external test lets them reach
  // the pins, so preloading is harmless. Capture-only cells keep their old value.
  always_ff @(posedge tck)
  begin
    if (rst_t2)
      bsr_upd <= '0;
    else if (tap_state == st_upd_dr && (dr_sel == sel_extest || dr_sel == sel_instr_a))
    begin
      for (int i = 0; i < BSR_LEN; i++)
      begin
        if (i != JTB_BIT_RST_IN && i != JTB_BIT_XTAL)
          bsr_upd[i] <= bsr_sr[i];
      end
    end
  end

  // Identification and bypass registers.
  always_ff @(posedge tck)
  begin
    if (rst_t2)
    begin
      id_sr <= '0;
      byp <= 1'b0;
    end
    else
    begin
      if (dr_sel == sel_id && tap_state == st_cap_dr)
        id_sr <= ID_VALUE;
      else if (dr_sel == sel_id && tap_state == st_shift_dr)
        id_sr <= {tdi, id_sr[JTB_ID_W-1:1]};
      if (dr_sel == sel_bypass && tap_state == st_cap_dr)
        byp <= 1'b0;
      else if (dr_sel == sel_bypass && tap_state == st_shift_dr)
        byp <= tdi;
    end
  end

  // Flash access registers share one shift path; the held word is read back on capture.
  always_comb
  begin
    fl_sel = 1'b1;
    fl_idx = 2'h0;
    case (dr_sel)
      sel_fl_ctrl: fl_idx = 2'h0;
      sel_fl_data: fl_idx = 2'h1;
      sel_fl_addr: fl_idx = 2'h2;
      sel_fl_scale: fl_idx = 2'h3;
      default: fl_sel = 1'b0;
    endcase
  end

  always_ff @(posedge tck)
  begin
    if (rst_t2)
    begin
      fl_sr <= '0;
      for (int r = 0; r < JTB_FLASH_REGS; r++)
        fl_hold[r] <= '0;
    end
    else if (fl_sel)
    begin
      if (tap_state == st_cap_dr)
        fl_sr <= fl_hold[fl_idx];
      else if (tap_state == st_shift_dr)
        fl_sr <= {tdi, fl_sr[FLASH_W-1:1]};
      else if (tap_state == st_upd_dr)
        fl_hold[fl_idx] <= fl_sr;
    end
  end

  // Serial output mux, chosen from the state the falling edge sees.
  always_comb
  begin
    next_tdo = 1'b0;
    if (tap_state == st_shift_ir)
      next_tdo = ir_sr[0];
    else
    begin
      case (dr_sel)
        sel_extest, sel_instr_a: next_tdo = bsr_sr[0];
        sel_id: next_tdo = id_sr[0];
        sel_bypass: next_tdo = byp;
        sel_fl_ctrl, sel_fl_data, sel_fl_addr, sel_fl_scale: next_tdo = fl_sr[0];
        default: next_tdo = byp;
      endcase
    end
  end

  // Data leaves on the falling edge so the tester can sample it on the next rise.
  always_ff @(negedge tck)
  begin
    if (rst_t2)
    begin
      tdo <= JTB_OUT_RESET;
      tdo_oe_n <= JTB_OE_N_RESET;
    end
    else
    begin
      tdo <= next_tdo;
      tdo_oe_n <= ~(tap_state == st_shift_ir || tap_state == st_shift_dr);
    end
  end

  chk_tms_reset:
    assert property (@(posedge tck) disable iff (rst_t2)
      tms [*5] |=> (tap_state == st_reset))
    else $error("five tms highs did not reach reset");

  chk_ir_capture:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_cap_ir) |=> (ir_sr == JTB_IR_CAPTURE))
    else $error("instruction capture pattern wrong");

  chk_ir_update:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_upd_ir) |=> (ir == $past(ir_sr)))
    else $error("instruction not taken on update");

  chk_ir_zero:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_reset) |=> (ir == 16'h0000 && dr_sel == sel_extest))
    else $error("instruction not zero after controller reset");

  chk_id_capture:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_cap_dr && dr_sel == sel_id) |=> (id_sr == ID_VALUE))
    else $error("identification value not captured");

  chk_bypass_capture:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_cap_dr && ir == 16'hffff) |=> (byp == 1'b0))
    else $error("bypass cell not cleared on capture");

  chk_unlisted_bypass:
    assert property (@(posedge tck) disable iff (rst_t2)
      (ir[15:8] != 8'h00) |-> (dr_sel == sel_bypass))
    else $error("unlisted instruction did not select bypass");

  chk_update_cells:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_upd_dr && dr_sel == sel_extest)
      |=> (bsr_upd[JTB_BIT_RST_EN] == $past(bsr_sr[JTB_BIT_RST_EN])
           && bsr_upd[JTB_BIT_RST_IN] == $past(bsr_upd[JTB_BIT_RST_IN])
           && bsr_upd[JTB_BIT_XTAL] == $past(bsr_upd[JTB_BIT_XTAL])))
    else $error("update cells wrong after update");

  chk_sample_mode:
    assert property (@(posedge tck) disable iff (rst_t2)
      (dr_sel == sel_instr_a) |=> !ext_mode)
    else $error("sample instruction left pins under chain control");

  chk_tdo_shift:
    assert property (@(posedge tck) disable iff (rst_t2)
      (tap_state == st_shift_dr && dr_sel == sel_bypass) ##1 (tap_state == st_shift_dr)
      |-> (tdo == $past(tdi)))
    else $error("bypass path does not delay by one cell");

endmodule : jtb_tap

// File: bench/jtb_tester.sv
// Purpose: Behavioural test controller driving the serial test pins of the port.
// Assumes: Test clock period of 30 ns, unrelated in phase to the system clock.
// Notes: The test clock stands still between frames; data in toggles when unused.
`timescale 1ns/100ps
module jtb_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels before the first frame.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period; signals change after the falling edge, data out is taken at the rise.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #15 tck = 1'b1;
    q = tdo;
    #15 tck = 1'b0;
  endtask : step

  // Mode high for five rises reaches reset from any state, then park in idle.
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : reset_tap

  // Walks from idle to a shift state; one extra idle rise lets pin levels cross first.
  task automatic enter(input logic ir);
    logic q;
    step(1'b0, ~tdi, q);
    step(1'b1, ~tdi, q);
    if (ir)
      step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : enter

  // Shifts n bits, first bit first, leaves on the last, then update and idle.
  task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic q;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~din[n-1], q);
    step(1'b0, din[n-1], q);
  endtask : shift

  // Loads an instruction and returns what the instruction register captured.
  task automatic scan_ir(input logic [15:0] code, output logic [15:0] cap);
    logic [127:0] o;
    enter(1'b1);
    shift(16, {112'h0, code}, o);
    cap = o[15:0];
  endtask : scan_ir

  // Scans n bits through the selected data register.
  task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    enter(1'b0);
    shift(n, din, dout);
  endtask : scan_dr
endmodule : jtb_tester

// File: bench/jtb_tap_test.sv
// Purpose: Self-checking bench for the test access port and boundary chain.
// Assumes: Larger package chain; the bench stands in for the pins and the core.
// Notes: Pin levels settle ten clocks before any capture, as the crossing needs.
`timescale 1ns/100ps
module jtb_tap_test;
  import jtb_pkg::*;
  localparam int N = (JTB_BSR_LEN_LARGE - JTB_BIT_PORT_BASE) / 2;
  // Identification value is arbitrary; bit 0 is set.
  localparam logic [31:0] ID = 32'h1c3e_7a95;
  logic clock, rst, tck, tms, tdi, tdo, tdo_oe_n, rst_pin_in, rst_pin_out, rst_pin_oe_n;
  logic crystal_input_pin, weak_pullup_en, core_rst_drive_en, core_weak_pullup_en, core_rst_in, core_xtal_in;
  logic [1:0] can_pin_in, can_pin_out, can_pin_oe_n, core_can_oe, core_can_out, core_can_in;
  logic [N-1:0] port_pin_in, port_pin_out, port_pin_oe_n, core_port_oe, core_port_out, core_port_in;
  int err_count = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////////
  jtb_tap #(.BSR_LEN(JTB_BSR_LEN_LARGE), .ID_VALUE(ID)) DUT (.clock, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
    .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .can_pin_in, .can_pin_out, .can_pin_oe_n, .crystal_input_pin,
    .port_pin_in, .port_pin_out, .port_pin_oe_n, .weak_pullup_en, .core_rst_drive_en, .core_can_oe,
    .core_can_out, .core_weak_pullup_en, .core_port_oe, .core_port_out, .core_rst_in, .core_can_in,
    .core_xtal_in, .core_port_in);
  // A released data output reads high through the tester's pull-up.
  jtb_tester tester (.tck, .tms, .tdi, .tdo(tdo_oe_n ? 1'b1 : tdo));

  // System clock at 50 MHz.
  initial clock = 1'b0;
  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  // Counts every comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Chain contents a capture must load from the present pin and core levels.
  function automatic logic [127:0] cap_exp();
    logic [127:0] e;
    e = '0;
    e[7:0] = {core_weak_pullup_en, crystal_input_pin, can_pin_in[1], core_can_oe[1], can_pin_in[0],
      core_can_oe[0], rst_pin_in, core_rst_drive_en};
    for (int k = 0; k < N; k++)
      e[8+2*k +: 2] = {port_pin_in[k], core_port_oe[k]};
    return e;
  endfunction : cap_exp

  // Pin outputs folded back into chain order; bits without update read zero.
  function automatic logic [127:0] pins_seen();
    logic [127:0] s;
    s = '0;
    s[7:0] = {weak_pullup_en, 1'b0, can_pin_out[1], ~can_pin_oe_n[1], can_pin_out[0], ~can_pin_oe_n[0],
      1'b0, ~rst_pin_oe_n};
    for (int k = 0; k < N; k++)
      s[8+2*k +: 2] = {port_pin_out[k], ~port_pin_oe_n[k]};
    return s;
  endfunction : pins_seen

  // New random pin and core levels at a falling edge, then time to settle and cross.
  task automatic set_pins();
    @(negedge clock);
    {rst_pin_in, crystal_input_pin, core_rst_drive_en, core_weak_pullup_en} = 4'($urandom);
    {can_pin_in, core_can_oe, core_can_out} = 6'($urandom);
    port_pin_in = N'({$urandom, $urandom});
    core_port_oe = N'({$urandom, $urandom});
    core_port_out = N'({$urandom, $urandom});
    repeat (10) @(negedge clock);
  endtask : set_pins

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the test clock runs during reset so its domain sees reset too.
  initial
  begin
    logic [127:0] v, o;
    logic [15:0] c, code;
    logic [7:0] fv [4];
    void'($urandom(32'hf0f06cf3));
    rst = 1'b1;
    {rst_pin_in, crystal_input_pin, core_rst_drive_en, core_weak_pullup_en} = 4'h0;
    {can_pin_in, core_can_oe, core_can_out} = 6'h00;
    {port_pin_in, core_port_oe, core_port_out} = '0;
    fork
      tester.reset_tap();
      repeat (20) @(negedge clock);
    join
    rst = 1'b0;
    tester.reset_tap();
    repeat (10) @(negedge clock);
    check("core_in_reset", {core_port_in, core_can_in, core_rst_in, core_xtal_in}, {(N+4){1'b1}});
    check("tdo_oe_n", tdo_oe_n, 1'b1);
    tester.scan_ir(JTB_OP_IDCODE, c);
    check("ir_capture", c, JTB_IR_CAPTURE);
    tester.scan_dr(32, 128'($urandom), o);
    check("id", o[31:0], ID);
    // Bypass by its own code, by a code beside the flash codes, and by random unlisted codes.
    for (int i = 0; i < 5; i++)
    begin
      code = (i == 0) ? JTB_OP_BYPASS : (i == 1) ? 16'h0086 : {1'b1, 15'($urandom)};
      tester.scan_ir(code, c);
      v = 128'($urandom);
      tester.scan_dr(8, v, o);
      check("bypass", o[7:0], {v[6:0], 1'b0});
    end
    // Each flash register keeps its own value; the second pass reads back the first.
    for (int i = 0; i < 8; i++)
    begin
      tester.scan_ir(JTB_OP_FL_CTRL + 16'(i % 4), c);
      v = 128'($urandom);
      tester.scan_dr(8, v, o);
      if (i > 3)
        check("flash_reg", o[7:0], fv[i%4]);
      fv[i%4] = v[7:0];
    end
    // External test and sample in turn; one extra bit proves the chain length.
    for (int i = 0; i < 6; i++)
    begin
      set_pins();
      tester.scan_ir(i[0] ? JTB_OP_INSTR_A : JTB_OP_EXTEST, c);
      v = {$urandom, $urandom, $urandom, $urandom};
      tester.scan_dr(127, v, o);
      check("chain_capture", o[125:0], cap_exp());
      check("chain_length", o[126], v[0]);
      repeat (10) @(negedge clock);
      if (!i[0])
      begin
        check("pins_updated", pins_seen(),
          v[126:1] & ~126'h42);
        check("core_in_forced", {core_port_in, core_can_in, core_rst_in, core_xtal_in}, {(N+4){1'b1}});
      end
      else
      begin
        check("pins_on_core", {port_pin_out, port_pin_oe_n, can_pin_out, can_pin_oe_n, weak_pullup_en},
          {core_port_out, ~core_port_oe, core_can_out, ~core_can_oe, core_weak_pullup_en});
        check("rst_pin_on_core", {rst_pin_oe_n, rst_pin_out}, {~core_rst_drive_en, 1'b0});
        check("core_in_follows", {core_port_in, core_can_in, core_rst_in, core_xtal_in},
          {port_pin_in, can_pin_in, rst_pin_in, crystal_input_pin});
      end
    end
    end_of_test();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge clock);
    err_count++;
    end_of_test();
  end
endmodule : jtb_tap_test
